//--- logic/seq_pkg.sv
// shared constants and types for the channel sequencer
package seq_pkg;

	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [14:0] STD_MASK_LO_ADDR = 15'h0010;
	localparam logic [14:0] STD_MASK_HI_ADDR = 15'h0011;
	localparam logic [14:0] SETUP_ADDR = 15'h0020;
	localparam logic [14:0] SEQUENCE_CONTROL_REG_ADDR = 15'h0024;
	localparam logic [14:0] TEMP_CTRL_ADDR = 15'h0029;
	localparam logic [14:0] CFG_BASE_ADDR = 15'h0030;
	localparam logic [14:0] CFG_LAST_ADDR = 15'h0037;
	localparam logic [14:0] SLOT_BASE_ADDR = 15'h0100;
	localparam logic [14:0] SLOT_LAST_ADDR = 15'h017F;

	// ************************************************
	// field positions and reset values
	// ************************************************
	localparam int SEQ_STD_EN_BIT = 7;
	localparam int COMMAND_LATENCY_SELECT_BIT = 1;
	localparam int TEMP_EN_BIT = 0;
	localparam logic [7:0] SEQUENCE_CONTROL_REG_RST = 8'h80;
	localparam logic [15:0] STD_MASK_RST = 16'h00FF;
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [7:0] TEMP_CTRL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [2:0] SLOT_RST = 3'h0;

	// ************************************************
	// channel codes, commands, frame counts
	// ************************************************
	localparam logic [3:0] CH_TEMP = 4'h8;
	localparam logic [1:0] CMD_IN_TAG = 2'h2;
	localparam logic [4:0] CMD_TEMP = 5'h0F;
	localparam logic [4:0] INSTR_LAST_BIT = 5'h0F;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
	localparam logic [4:0] READ_SHIFT_FROM = 5'h10;
	localparam logic [2:0] CMD_LATCH_FALL = 3'h5;

	typedef enum {MODE_STD, MODE_ADV, MODE_CMD2, MODE_CMD1} seq_mode_t;

	typedef struct packed {
		logic [1:0] spare;
		logic [1:0] osr;
		logic thresh_en;
		logic hiz_en;
		logic paired;
		logic polarity;
	} input_cfg_t;

endpackage

//--- logic/adc_channel_sequencer.sv
// multiplexer channel sequencer with serial register access
// Function
// [R1] mux changes at most once per period, at acquisition start
// [R2] mode decoded from enable, slot count and latency select
// [R3] standard mode visits enabled inputs ascending, wrapping
// [R4] standard mode advances whenever a result is ready
// [R5] eight-bit mask, bit one means input in sequence
// [R6] temperature enable appends sensor after last enabled input
// [R7] reset selects the standard sequencer
// [R8] config mode with enable set routes first enabled channel
// [R9] standard mode uses input zero config except polarity
// [R10] standard mode holds channel until oversampling count done
// [R11] advanced mode steps 2 to 128 slots from slot 0, repeating
// [R12] each slot names any input, slot n at 0x100 plus n
// [R13] temperature appended after last slot, never selectable by slot
// [R14] config mode with enable clear routes slot zero input
// [R15] advanced mode uses each input's own config and ratio
// [R16] advanced oversampling holds slot and busy until done
// [R17] paired odd input behaves as its even partner
// [R18] each enabled input converted once per pass
// [R19] sequencer modes need no host channel data
// [R20] command modes steer mux from host 5-bit commands
// [R21] command sampled on five rising edges, latched sixth falling
// [R22] invalid command is a no-op, channel repeats
// [R23] busy high during conversion, low when result ready
// [R24] advanced length is slot count field plus one
// [R25] entering conversion mode restarts the sequence
`timescale 1ns/100ps
module adc_channel_sequencer
	import seq_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// serial port pins
	input wire logic spi_cs_n_i,
	input wire logic spi_sck_i,
	input wire logic spi_sdi_i,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	// conversion start pin and core status
	input wire logic conversion_start_pin_i,
	input wire logic conversion_mode_i,
	input wire logic conv_done_i,
	// to the multiplexer and core
	output logic [3:0] mux_sel_o,
	output input_cfg_t mux_cfg_o,
	output logic general_pin_zero_o,
	output logic [1:0] seq_mode_o
);

	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_st_q, pin_st_d;
	logic cnv_rise, sck_rise, sck_fall, cs_act;

	// a change counts once the last two stages agree
	always_comb begin
		pin_st_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_st_q & (pin_s2_q ^ pin_s3_q));
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1_q <= 4'h6;
			pin_s2_q <= 4'h6;
			pin_s3_q <= 4'h6;
			pin_st_q <= 4'h6;
		end else begin
			pin_s1_q <= {conversion_start_pin_i, spi_cs_n_i, spi_sck_i, spi_sdi_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_st_q <= pin_st_d;
		end
	end

	assign cs_act = ~pin_st_q[2];
	assign cnv_rise = pin_st_d[3] & ~pin_st_q[3];
	assign sck_rise = cs_act & pin_st_d[1] & ~pin_st_q[1];
	assign sck_fall = cs_act & ~pin_st_d[1] & pin_st_q[1];

	// ************************************************
	// registers
	// ************************************************
	logic [7:0] sequence_control_reg_q, setup_q, temp_ctrl_q;
	logic [15:0] std_mask_q;
	input_cfg_t cfg_q [8];
	logic [2:0] slot_q [128];
	logic [23:0] shift_q;
	logic [4:0] bit_cnt_q;
	logic [2:0] fall_cnt_q;
	logic [7:0] rd_q, rd_data;
	logic reading_q, wr_en;
	logic [23:0] word;
	logic [14:0] wr_addr, rd_addr;

	assign word = {shift_q[22:0], pin_st_d[0]};
	assign wr_addr = word[22:8];
	assign rd_addr = word[14:0];
	// writes only in configuration mode, frame bit 23 low
	assign wr_en = sck_rise & ~conversion_mode_i & (bit_cnt_q == FRAME_LAST_BIT) & ~shift_q[22];

	// read-back decode
	always_comb begin
		rd_data = 8'h00;
		if (rd_addr == SEQUENCE_CONTROL_REG_ADDR) begin
			rd_data = sequence_control_reg_q;
		end else if (rd_addr == SETUP_ADDR) begin
			rd_data = setup_q;
		end else if (rd_addr == TEMP_CTRL_ADDR) begin
			rd_data = temp_ctrl_q;
		end else if (rd_addr == STD_MASK_LO_ADDR) begin
			rd_data = std_mask_q[7:0];
		end else if (rd_addr == STD_MASK_HI_ADDR) begin
			rd_data = std_mask_q[15:8];
		end else if (rd_addr >= CFG_BASE_ADDR && rd_addr <= CFG_LAST_ADDR) begin
			rd_data = cfg_q[rd_addr[2:0]];
		end else if (rd_addr >= SLOT_BASE_ADDR && rd_addr <= SLOT_LAST_ADDR) begin
			rd_data = {5'h00, slot_q[rd_addr[6:0]]};
		end
	end

	// register writes; reset selects the standard sequencer
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// [R7] standard by default
			sequence_control_reg_q <= SEQUENCE_CONTROL_REG_RST;
			setup_q <= SETUP_RST;
			temp_ctrl_q <= TEMP_CTRL_RST;
			std_mask_q <= STD_MASK_RST;
			for (int i = 0; i < 8; i++) begin
				cfg_q[i] <= CFG_RST;
			end
			for (int i = 0; i < 128; i++) begin
				slot_q[i] <= SLOT_RST;
			end
		end else if (wr_en) begin
			if (wr_addr == SEQUENCE_CONTROL_REG_ADDR) begin
				sequence_control_reg_q <= word[7:0];
			end else if (wr_addr == SETUP_ADDR) begin
				setup_q <= word[7:0];
			end else if (wr_addr == TEMP_CTRL_ADDR) begin
				temp_ctrl_q <= word[7:0];
			end else if (wr_addr == STD_MASK_LO_ADDR) begin
				std_mask_q[7:0] <= word[7:0];
			end else if (wr_addr == STD_MASK_HI_ADDR) begin
				std_mask_q[15:8] <= word[7:0];
			end else if (wr_addr >= CFG_BASE_ADDR && wr_addr <= CFG_LAST_ADDR) begin
				cfg_q[wr_addr[2:0]] <= word[7:0];
			end else if (wr_addr >= SLOT_BASE_ADDR && wr_addr <= SLOT_LAST_ADDR) begin
				// [R12] slot n field, any of eight inputs
				slot_q[wr_addr[6:0]] <= word[2:0];
			end
		end
	end

	// ************************************************
	// serial frame shifter
	// ************************************************
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= 24'h000000;
			bit_cnt_q <= 5'h00;
			fall_cnt_q <= 3'h0;
			rd_q <= 8'h00;
			reading_q <= 1'b0;
		end else if (!cs_act) begin
			bit_cnt_q <= 5'h00;
			fall_cnt_q <= 3'h0;
			reading_q <= 1'b0;
		end else begin
			if (sck_rise) begin
				shift_q <= word;
				if (bit_cnt_q != 5'h1F) begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
				end
				// instruction done: load read byte, msb first
				if (bit_cnt_q == INSTR_LAST_BIT && word[15] && !conversion_mode_i) begin
					rd_q <= rd_data;
					reading_q <= 1'b1;
				end
			end
			if (sck_fall) begin
				if (fall_cnt_q != 3'h7) begin
					fall_cnt_q <= fall_cnt_q + 3'h1;
				end
				if (bit_cnt_q > READ_SHIFT_FROM) begin
					rd_q <= {rd_q[6:0], 1'b0};
				end
			end
		end
	end

	assign spi_sdo_o = rd_q[7];
	assign spi_sdo_oe_o = cs_act & reading_q;

	// ************************************************
	// decode helpers
	// ************************************************
	// [R2] four-way mode selection
	function automatic seq_mode_t decode_mode(input logic [7:0] sc, input logic cyc);
		if (sc[SEQ_STD_EN_BIT]) begin
			return MODE_STD;
		end else if (sc[6:0] != 7'h00 && !cyc) begin
			return MODE_ADV;
		end else if (!cyc) begin
			return MODE_CMD2;
		end else begin
			return MODE_CMD1;
		end
	endfunction

	// [R5] lowest enabled input, sensor if none and enabled
	function automatic logic [3:0] first_std(input logic [7:0] m, input logic t);
		first_std = t ? CH_TEMP : 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (m[i]) begin
				first_std = 4'(i);
			end
		end
	endfunction

	// [R3] next enabled input above current, else sensor, else wrap
	function automatic logic [3:0] next_std(input logic [3:0] c, input logic [7:0] m, input logic t);
		next_std = first_std(m, t);
		// [R6] sensor after last input
		if (t && c != CH_TEMP) begin
			next_std = CH_TEMP;
		end
		for (int i = 7; i >= 0; i--) begin
			if (m[i] && 4'(i) > c && c != CH_TEMP) begin
				next_std = 4'(i);
			end
		end
	endfunction

	// [R9] standard mode borrows input zero settings but own polarity
	function automatic input_cfg_t cfg_of(input logic [3:0] c, input logic std);
		input_cfg_t r;
		r = std ? cfg_q[0] : cfg_q[c[2:0]];
		r.polarity = cfg_q[c[2:0]].polarity;
		if (c == CH_TEMP) begin
			r = cfg_q[0];
			r.osr = 2'h0;
		end
		return r;
	endfunction

	// ************************************************
	// sequencer
	// ************************************************
	seq_mode_t mode;
	logic [3:0] ch_q, ch_d, pend_ch_q, pend_ch_d, first_ch, mux_d;
	logic [6:0] slot_idx_q, slot_idx_d, osr_cnt_q, osr_cnt_d, osr_need;
	logic pend_q, pend_d, busy_q, busy_d, temp_en, is_std, cmd_latch, cmd_ok;
	logic [3:0] cmd_ch;
	input_cfg_t cur_cfg, next_cfg;

	assign mode = decode_mode(sequence_control_reg_q, setup_q[COMMAND_LATENCY_SELECT_BIT]);
	assign is_std = (mode == MODE_STD);
	assign temp_en = temp_ctrl_q[TEMP_EN_BIT];
	assign first_ch = first_std(std_mask_q[7:0], temp_en);
	// process form, so a config write alone re-evaluates the lookup
	always_comb begin
		cur_cfg = cfg_of(ch_q, is_std);
	end
	// [R15] ratio from the channel's own config outside standard mode
	assign osr_need = 7'h01 << {cur_cfg.osr, 1'b0};
	// [R21] command latched on sixth falling edge
	assign cmd_latch = sck_fall & conversion_mode_i & (fall_cnt_q == CMD_LATCH_FALL);
	// [R22] only input or sensor codes are valid
	assign cmd_ok = (shift_q[4:3] == CMD_IN_TAG) || (shift_q[4:0] == CMD_TEMP);
	assign cmd_ch = (shift_q[4:0] == CMD_TEMP) ? CH_TEMP : {1'b0, shift_q[2:0]};

	always_comb begin
		ch_d = ch_q;
		slot_idx_d = slot_idx_q;
		osr_cnt_d = osr_cnt_q;
		busy_d = busy_q;
		pend_d = pend_q;
		pend_ch_d = pend_ch_q;
		if (!conversion_mode_i) begin
			// [R8] [R14] [R25] preselect start channel
			ch_d = is_std ? first_ch : {1'b0, slot_q[0]};
			slot_idx_d = 7'h00;
			osr_cnt_d = 7'h00;
			busy_d = 1'b0;
			pend_d = 1'b0;
		end else begin
			// [R20] host command steers the mux
			if (cmd_latch && cmd_ok && mode == MODE_CMD1) begin
				ch_d = cmd_ch;
			end else if (cmd_latch && cmd_ok && mode == MODE_CMD2) begin
				pend_d = 1'b1;
				pend_ch_d = cmd_ch;
			end
			if (conv_done_i) begin
				// [R10] [R16] hold channel and busy through oversampling
				if (osr_cnt_q + 7'h01 >= osr_need) begin
					osr_cnt_d = 7'h00;
					// [R23] busy falls with the result
					busy_d = 1'b0;
					// [R1] [R4] [R19] single step at acquisition start
					case (mode)
						MODE_STD: begin
							// [R18] each enabled input once per pass
							ch_d = next_std(ch_q, std_mask_q[7:0], temp_en);
						end
						MODE_ADV: begin
							// [R11] [R24] [R13] slot walk, sensor after last
							if (ch_q == CH_TEMP || (slot_idx_q == sequence_control_reg_q[6:0] && !temp_en)) begin
								slot_idx_d = 7'h00;
								ch_d = {1'b0, slot_q[0]};
							end else if (slot_idx_q == sequence_control_reg_q[6:0]) begin
								ch_d = CH_TEMP;
							end else begin
								slot_idx_d = slot_idx_q + 7'h01;
								ch_d = {1'b0, slot_q[slot_idx_q + 7'h01]};
							end
						end
						MODE_CMD2: begin
							if (pend_q) begin
								ch_d = pend_ch_q;
								pend_d = 1'b0;
							end
						end
						default: begin
							ch_d = ch_q;
						end
					endcase
				end else begin
					osr_cnt_d = osr_cnt_q + 7'h01;
				end
			end
			// [R23] a new conversion raises busy
			if (cnv_rise) begin
				busy_d = 1'b1;
			end
		end
	end

	// [R17] paired odd input folds onto its even partner
	always_comb begin
		next_cfg = cfg_of(ch_d, is_std);
		mux_d = ch_d;
		if (ch_d != CH_TEMP && ch_d[0] && (is_std ? cfg_q[0].paired : cfg_q[{ch_d[2:1], 1'b0}].paired)) begin
			mux_d = {ch_d[3:1], 1'b0};
		end
	end

	// sequencer state
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ch_q <= 4'h0;
			slot_idx_q <= 7'h00;
			osr_cnt_q <= 7'h00;
			busy_q <= 1'b0;
			pend_q <= 1'b0;
			pend_ch_q <= 4'h0;
		end else begin
			ch_q <= ch_d;
			slot_idx_q <= slot_idx_d;
			osr_cnt_q <= osr_cnt_d;
			busy_q <= busy_d;
			pend_q <= pend_d;
			pend_ch_q <= pend_ch_d;
		end
	end

	// outputs to the core, all from flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mux_sel_o <= 4'h0;
			mux_cfg_o <= CFG_RST;
			seq_mode_o <= 2'h0;
		end else begin
			mux_sel_o <= mux_d;
			mux_cfg_o <= next_cfg;
			seq_mode_o <= 2'(mode);
		end
	end

	assign general_pin_zero_o = busy_q;

endmodule

//--- bench/spi_host_model.sv
// host model: serial frames toward the sequencer
`timescale 1ns/100ps
module spi_host_model (
	// clock
	input wire logic clk_i,
	// serial pins
	output logic cs_n_o,
	output logic sck_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	// clocks per sck level, raised by the bench for a slow host
	int hold = 5;

	// idle: deselected, clock parked high
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b1;
		sdi_o = 1'b0;
	end

	// ************************
	// one frame, msb first
	// ************************
	// bits on rises, a fall before each, so >= 6 falls
	task automatic xfer(input logic [23:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk_i) #1 cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (hold) @(posedge clk_i);
			#1 sck_o = 1'b0;
			sdi_o = w[23 - i];
			repeat (hold) @(posedge clk_i);
			#1 sck_o = 1'b1;
			if (i >= 16) rd = {rd[6:0], sdo_i};
		end
		repeat (hold) @(posedge clk_i);
		#1 cs_n_o = 1'b1;
		// flipped data line: the inverse of the last bit is left behind
		sdi_o = ~sdi_o;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

//--- bench/adc_channel_sequencer_assertions.sv
// port checker for the channel sequencer
`timescale 1ns/100ps
module seq_checker
	import seq_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// serial pins
	input wire logic spi_cs_n_i,
	input wire logic spi_sck_i,
	input wire logic spi_sdi_i,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe_o,
	// conversion side
	input wire logic conversion_start_pin_i,
	input wire logic conversion_mode_i,
	input wire logic conv_done_i,
	input wire logic [3:0] mux_sel_o,
	input wire input_cfg_t mux_cfg_o,
	input wire logic general_pin_zero_o,
	input wire logic [1:0] seq_mode_o
);
	// shared config fields, without polarity
	wire [4:0] shared_f = mux_cfg_o[5:1];

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	// ************************
	// assertions
	// ************************
	AST_MUX_ON_DONE: assert property (conversion_mode_i && $past(conversion_mode_i, 2) && !seq_mode_o[1]
		&& $changed(mux_sel_o) |-> $past(conv_done_i)) else $error("mux moved without a result");
	AST_RESET_STD: assert property ($rose(rst_n_i) |-> seq_mode_o == 2'h0)
		else $error("reset mode not standard");
	AST_BUSY_FALL: assert property ($fell(general_pin_zero_o) && $past(conversion_mode_i)
		|-> $past(conv_done_i)) else $error("busy fell without a result");
	AST_BUSY_RISE: assert property ($rose(conversion_start_pin_i) && conversion_mode_i && !conv_done_i
		|-> ##[1:6] general_pin_zero_o) else $error("busy missing after start");
	AST_CFG_IDLE: assert property (!conversion_mode_i [*2] |-> !general_pin_zero_o)
		else $error("busy in config mode");
	AST_SEL_RANGE: assert property (mux_sel_o <= CH_TEMP)
		else $error("channel code out of range");
	AST_PAIR_EVEN: assert property (mux_cfg_o.paired && mux_sel_o != CH_TEMP |-> !mux_sel_o[0])
		else $error("paired odd input selected");
	// five deselected samples cover the pin synchroniser delay
	AST_OE_IDLE: assert property (spi_cs_n_i [*5] |-> !spi_sdo_oe_o)
		else $error("read data driven while deselected");
	AST_STD_SHARED: assert property (seq_mode_o == 2'h0 && $past(seq_mode_o) == 2'h0 && conversion_mode_i
		&& $past(conversion_mode_i) && mux_sel_o != CH_TEMP && $past(mux_sel_o) != CH_TEMP
		|-> shared_f == $past(shared_f)) else $error("shared config differs");

	// main scenarios seen
	COV_RESULT: cover property ($fell(general_pin_zero_o));
	COV_TEMP: cover property (conversion_mode_i && mux_sel_o == CH_TEMP);
	COV_CMD1: cover property (conversion_mode_i && seq_mode_o == 2'h3);
endmodule

bind adc_channel_sequencer seq_checker u_chk (.clk_sys_i, .rst_n_i, .spi_cs_n_i, .spi_sck_i, .spi_sdi_i,
	.spi_sdo_o, .spi_sdo_oe_o, .conversion_start_pin_i, .conversion_mode_i, .conv_done_i, .mux_sel_o,
	.mux_cfg_o, .general_pin_zero_o, .seq_mode_o);

//--- bench/tb_top.sv
// self-checking bench for the channel sequencer
`timescale 1ns/100ps
module tb_top
	import seq_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic conversion_start_pin_i = 1'b0;
	logic conversion_mode_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic spi_cs_n_i, spi_sck_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_o, general_pin_zero_o;
	logic [3:0] mux_sel_o;
	logic [1:0] seq_mode_o;
	input_cfg_t mux_cfg_o;
	logic [7:0] rd;
	int err_total = 0;
	int checks_done = 0;
	logic oe_seen = 1'b0;

	always #5 clk_sys_i = ~clk_sys_i;

	// remembers that read data was ever driven
	always @(posedge clk_sys_i) begin
		if (spi_sdo_oe_o === 1'b1) oe_seen <= 1'b1;
	end

	adc_channel_sequencer uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
		.spi_sck_i(spi_sck_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
		.conversion_start_pin_i(conversion_start_pin_i), .conversion_mode_i(conversion_mode_i),
		.conv_done_i(conv_done_i), .mux_sel_o(mux_sel_o), .mux_cfg_o(mux_cfg_o),
		.general_pin_zero_o(general_pin_zero_o), .seq_mode_o(seq_mode_o));
	spi_host_model u_host (.clk_i(clk_sys_i), .cs_n_o(spi_cs_n_i), .sck_o(spi_sck_i), .sdi_o(spi_sdi_i),
		.sdo_i(spi_sdo_o));

	// ************************
	// helpers
	// ************************
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		u_host.xfer({1'b0, a, d}, 24, rd);
	endtask
	task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
		u_host.xfer({1'b1, a, 8'h00}, 24, rd);
		chk(rd, exp);
	endtask
	task automatic cmd(input logic [4:0] c);
		u_host.xfer({c, 19'h0}, 8, rd);
	endtask
	task automatic mode(input logic m);
		@(posedge clk_sys_i) #1 conversion_mode_i = m;
		repeat (3) @(posedge clk_sys_i);
	endtask
	// bounded wait for busy high, looked at off the edge
	task automatic wbusy();
		int n;
		n = 0;
		while (general_pin_zero_o !== 1'b1 && n < 20) begin
			@(posedge clk_sys_i) #1;
			n++;
		end
		if (general_pin_zero_o !== 1'b1) begin
			err_total++;
			print_verdict();
		end
	endtask
	// reps conversions on one channel, then the next one
	// result waits until the start edge is through the synchroniser,
	// otherwise start and result meet and busy re-rises
	task automatic conv(input int reps, input logic [3:0] held, input logic [3:0] nxt);
		for (int i = 1; i <= reps; i++) begin
			@(posedge clk_sys_i) #1 conversion_start_pin_i = 1'b1;
			repeat (2) @(posedge clk_sys_i);
			#1 conversion_start_pin_i = 1'b0;
			repeat (2) @(posedge clk_sys_i);
			#1;
			wbusy();
			chk({4'h0, mux_sel_o}, {4'h0, held});
			@(posedge clk_sys_i) #1 conv_done_i = 1'b1;
			@(posedge clk_sys_i) #1 conv_done_i = 1'b0;
			@(posedge clk_sys_i) #1;
			chk({7'h0, general_pin_zero_o}, (i < reps) ? 8'h01 : 8'h00);
		end
		chk({4'h0, mux_sel_o}, {4'h0, nxt});
	endtask

	// ************************
	// scenarios
	// ************************
	initial begin
		repeat (2) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		chk({6'h0, seq_mode_o}, 8'h00);
		chk({4'h0, mux_sel_o}, 8'h00);
		rdc(SEQUENCE_CONTROL_REG_ADDR, SEQUENCE_CONTROL_REG_RST);
		chk({7'h0, oe_seen}, 8'h01);
		rdc(STD_MASK_LO_ADDR, 8'hFF);
		u_host.hold = 8;
		rdc(15'h0050, 8'h00);
		u_host.hold = 5;
		wr(STD_MASK_LO_ADDR, 8'h84);
		chk({4'h0, mux_sel_o}, 8'h02);
		wr(STD_MASK_LO_ADDR, 8'h85);
		wr(TEMP_CTRL_ADDR, 8'h01);
		rdc(STD_MASK_LO_ADDR, 8'h85);
		mode(1'b1);
		conv(1, 4'h0, 4'h2);
		conv(1, 4'h2, 4'h7);
		conv(1, 4'h7, CH_TEMP);
		conv(1, CH_TEMP, 4'h0);
		conv(1, 4'h0, 4'h2);
		mode(1'b0);
		mode(1'b1);
		chk({4'h0, mux_sel_o}, 8'h00);
		mode(1'b0);
		wr(CFG_BASE_ADDR, 8'h02);
		wr(STD_MASK_LO_ADDR, 8'h02);
		chk({4'h0, mux_sel_o}, 8'h00);
		wr(CFG_BASE_ADDR, 8'h10);
		wr(CFG_BASE_ADDR + 15'h2, 8'h21);
		wr(STD_MASK_LO_ADDR, 8'h05);
		wr(TEMP_CTRL_ADDR, 8'h00);
		mode(1'b1);
		conv(4, 4'h0, 4'h2);
		chk(mux_cfg_o, 8'h11);
		conv(4, 4'h2, 4'h0);
		mode(1'b0);
		wr(SEQUENCE_CONTROL_REG_ADDR, 8'h02);
		wr(SLOT_BASE_ADDR, 8'h06);
		wr(SLOT_BASE_ADDR + 15'h1, 8'h05);
		wr(SLOT_BASE_ADDR + 15'h2, 8'h03);
		wr(CFG_BASE_ADDR + 15'h5, 8'h10);
		wr(TEMP_CTRL_ADDR, 8'h01);
		chk({6'h0, seq_mode_o}, 8'h01);
		chk({4'h0, mux_sel_o}, 8'h06);
		mode(1'b1);
		conv(1, 4'h6, 4'h5);
		conv(4, 4'h5, 4'h3);
		conv(1, 4'h3, CH_TEMP);
		conv(1, CH_TEMP, 4'h6);
		mode(1'b0);
		wr(SEQUENCE_CONTROL_REG_ADDR, 8'h00);
		wr(SETUP_ADDR, 8'h02);
		chk({6'h0, seq_mode_o}, 8'h03);
		mode(1'b1);
		cmd(5'h14);
		chk({4'h0, mux_sel_o}, 8'h04);
		cmd(5'h1F);
		chk({4'h0, mux_sel_o}, 8'h04);
		cmd(CMD_TEMP);
		chk({4'h0, mux_sel_o}, {4'h0, CH_TEMP});
		mode(1'b0);
		wr(SETUP_ADDR, 8'h00);
		chk({6'h0, seq_mode_o}, 8'h02);
		mode(1'b1);
		cmd(5'h11);
		chk({4'h0, mux_sel_o}, 8'h06);
		conv(1, 4'h6, 4'h1);
		mode(1'b0);
		// mid-run reset must bring back the standard sequencer
		@(posedge clk_sys_i) #1 rst_n_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		chk({6'h0, seq_mode_o}, 8'h00);
		rdc(SEQUENCE_CONTROL_REG_ADDR, SEQUENCE_CONTROL_REG_RST);
		print_verdict();
	end
endmodule
